/* File: verilog/imc_ctrl.sv */
/*
   imc_ctrl: device-side control of in-system programming modes (normal,
   real-time background, clamp) and of the I/O pin behaviour in each mode.
   Assumes the programming host reaches it over the plain register port,
   all inputs synchronous to clock, and that rstn is the power-up reset.
*/
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps

// Overview of operation
// R1: normal programming finished: copy config flash contents into config SRAM.
// R2: normal programming and following SRAM load keep all I/O pins tri-stated.
// R3: after SRAM load, reset the core, then run user mode.
// R4: normal programming without clamp: pins tri-stated with weak pull-up.
// R5: real-time programming: user flash, logic and pins keep working.
// R6: after real-time programming keep old design until a power cycle.
// R7: after power cycle load flash to SRAM, user mode after load time.
// R8: host starts real-time programming only while device is in user mode.
// R9: clamp mode holds each pin at its own fixed state during programming.
// R10: clamp choices: high impedance (default), high, low, or sampled pin value.
// R11: any clamp use disables weak pull-ups, even for tri-state pins.
// R12: host preloads clamp values into boundary cells before clamping.
// R13: host then issues external test; device drives pins from cells.
// R14: clamped programming done: release pins and run new design.
// R15: host keeps sample-and-hold pins steady while they are sampled.
// R16: host never mixes clamp mode with real-time programming.
// R17: hold option captures pin level at preload, driven out during external test.
module imc_ctrl
#(
   parameter int CFG_LOAD_CYC = imc_pkg::CFG_LOAD_CYC_DEF
)
(
   // clock and reset
   input  wire logic                      clock,
   input  wire logic                      rstn,
   // register port
   input  wire logic [imc_pkg::AW-1:0]    reg_addr,
   input  wire logic [imc_pkg::DW-1:0]    reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output      logic [imc_pkg::DW-1:0]    reg_rdata,
   // device pins
   input  wire logic [imc_pkg::NPIN-1:0]  pin_in,
   output      logic [imc_pkg::NPIN-1:0]  pin_out,
   output      logic [imc_pkg::NPIN-1:0]  pin_oe,
   output      logic [imc_pkg::NPIN-1:0]  pin_pullup_en,
   // user logic side
   input  wire logic [imc_pkg::NPIN-1:0]  user_out,
   input  wire logic [imc_pkg::NPIN-1:0]  user_oe,
   output      logic [imc_pkg::NPIN-1:0]  user_in,
   // configuration memory and core
   output      logic                      sram_load,
   output      logic                      core_rst,
   output      logic                      user_mode
);
   import imc_pkg::*;

   imc_regs_t r_r;
   imc_regs_t r_nxt;

   logic wr_ctrl;
   logic wr_cmd;
   logic wr_clamp;
   logic cmd_start;
   logic cmd_done;
   logic cmd_preload;
   logic cmd_extest;
   logic cmd_clrerr;

   assign wr_ctrl     = reg_wr && (reg_addr == ADDR_CTRL);
   assign wr_cmd      = reg_wr && (reg_addr == ADDR_CMD);
   assign wr_clamp    = reg_wr && (reg_addr == ADDR_CLAMP);
   assign cmd_start   = wr_cmd && reg_wdata[CMD_START_BIT];
   assign cmd_done    = wr_cmd && reg_wdata[CMD_DONE_BIT];
   assign cmd_preload = wr_cmd && reg_wdata[CMD_PRELOAD_BIT];
   assign cmd_extest  = wr_cmd && reg_wdata[CMD_EXTEST_BIT];
   assign cmd_clrerr  = wr_cmd && reg_wdata[CMD_CLRERR_BIT];

   always_comb
   begin
      r_nxt       = r_r;
      r_nxt.rdata = '0;
      case (r_r.state)
         S_LOAD:
         begin
            // flash contents copied into SRAM; pins stay tri-stated
            if (r_r.cnt == 16'(CFG_LOAD_CYC - 1)) // R1 R7
            begin
               r_nxt.state = S_CORE_RST;
               r_nxt.cnt   = '0;
            end
            else
            begin
               r_nxt.cnt = r_r.cnt + 16'h0001;
            end
         end
         S_CORE_RST:
         begin
            if (r_r.cnt == 16'(CORE_RST_CYC - 1)) // R3
            begin
               r_nxt.state = S_USER;
               r_nxt.cnt   = '0;
            end
            else
            begin
               r_nxt.cnt = r_r.cnt + 16'h0001;
            end
         end
         S_USER:
         begin
            if (wr_ctrl)
            begin
               r_nxt.rt_en    = reg_wdata[CTRL_RT_BIT];
               r_nxt.clamp_en = reg_wdata[CTRL_CLAMP_BIT];
            end
            if (cmd_start)
            begin
               // mixing clamp with background programming is refused
               if (r_r.rt_en && r_r.clamp_en) // R16
               begin
                  r_nxt.err_combo = 1'b1;
               end
               else if (r_r.rt_en) // R5 R8
               begin
                  r_nxt.state = S_RTPROG;
               end
               else
               begin
                  r_nxt.state = S_PROG;
               end
            end
         end
         S_PROG:
         begin
            if (cmd_done)
            begin
               r_nxt.state  = S_LOAD; // R1
               r_nxt.cnt    = '0;
               r_nxt.extest = 1'b0; // R14
            end
         end
         S_RTPROG:
         begin
            if (cmd_done)
            begin
               // old design keeps running; only a power-up reloads
               r_nxt.state       = S_USER; // R6
               r_nxt.update_pend = 1'b1;
            end
         end
         default:
         begin
            r_nxt.state = S_LOAD;
            r_nxt.cnt   = '0;
         end
      endcase

      // codes only change in user mode, so a clamp in force cannot be altered
      if (wr_clamp && (r_r.state == S_USER))
      begin
         r_nxt.clamp_sel = reg_wdata[15:0];
      end
      // cells are frozen while they drive the pins
      if (cmd_preload && !r_r.extest) // R12
      begin
         for (int i = 0; i < NPIN; i++)
         begin
            case (imc_clamp_t'(r_r.clamp_sel[2*i +: 2])) // R10
               CLAMP_HIGH:
               begin
                  r_nxt.cell_val[i] = 1'b1;
                  r_nxt.cell_oe[i]  = 1'b1;
               end
               CLAMP_LOW:
               begin
                  r_nxt.cell_val[i] = 1'b0;
                  r_nxt.cell_oe[i]  = 1'b1;
               end
               CLAMP_HOLD:
               begin
                  r_nxt.cell_val[i] = pin_in[i]; // R17
                  r_nxt.cell_oe[i]  = 1'b1;
               end
               default:
               begin
                  r_nxt.cell_val[i] = 1'b0;
                  r_nxt.cell_oe[i]  = 1'b0;
               end
            endcase
         end
      end
      // extest outlives START so the pins stay clamped through programming
      if (cmd_extest && r_r.clamp_en && !cmd_done &&
          ((r_r.state == S_USER) || (r_r.state == S_PROG))) // R13
      begin
         r_nxt.extest = 1'b1;
      end
      // a refusal in the same cycle as the clear is kept
      if (cmd_clrerr && !(cmd_start && r_r.rt_en && r_r.clamp_en &&
                          (r_r.state == S_USER)))
      begin
         r_nxt.err_combo = 1'b0;
      end

      if (reg_rd)
      begin
         case (reg_addr)
            ADDR_CTRL:  r_nxt.rdata = {30'h0000_0000, r_r.clamp_en, r_r.rt_en};
            ADDR_CLAMP: r_nxt.rdata = {16'h0000, r_r.clamp_sel};
            ADDR_STAT:
            begin
               r_nxt.rdata = {24'h00_0000, r_r.state == S_USER,
                              r_r.state == S_LOAD, r_r.err_combo,
                              r_r.update_pend, r_r.extest, r_r.state};
            end
            ADDR_CELL:  r_nxt.rdata = {16'h0000, r_r.cell_oe, r_r.cell_val};
            default:    r_nxt.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         // power-up: always start with a fresh load from flash
         r_r <= '{state: S_LOAD, cnt: 16'h0000, rt_en: CTRL_RST[CTRL_RT_BIT],
                  clamp_en: CTRL_RST[CTRL_CLAMP_BIT], clamp_sel: CLAMP_RST,
                  cell_val: '0, cell_oe: '0, extest: 1'b0, update_pend: 1'b0,
                  err_combo: 1'b0, rdata: '0}; // R7
      end
      else
      begin
         r_r <= r_nxt;
      end
   end

   assign reg_rdata = r_r.rdata;
   assign sram_load = (r_r.state == S_LOAD);
   assign core_rst  = (r_r.state == S_CORE_RST);
   assign user_mode = (r_r.state == S_USER) || (r_r.state == S_RTPROG);
   assign user_in   = pin_in;

   // pads are combinational so a clamp takes hold the cycle after its command
   always_comb
   begin
      if (r_r.extest) // R9 R13
      begin
         pin_out       = r_r.cell_val;
         pin_oe        = r_r.cell_oe;
         pin_pullup_en = '0; // R11
      end
      else
      begin
         case (r_r.state)
            S_USER, S_RTPROG: // R5
            begin
               pin_out       = user_out;
               pin_oe        = user_oe;
               pin_pullup_en = '0;
            end
            S_PROG:
            begin
               pin_out       = '0;
               pin_oe        = '0; // R2
               pin_pullup_en = r_r.clamp_en ? '0 : '1; // R4 R11
            end
            default:
            begin
               pin_out       = '0;
               pin_oe        = '0; // R2
               pin_pullup_en = '1;
            end
         endcase
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   a_load_after_prog: assert property ((r_r.state == S_PROG) && cmd_done // R1
      |=> sram_load && (pin_oe == '0)) else $error("no SRAM load after programming");
   a_prog_tristate: assert property ((sram_load || (r_r.state == S_PROG)) && !r_r.extest // R2
      |-> pin_oe == '0) else $error("pins driven during programming");
   a_reset_then_user: assert property ($fell(sram_load) && $past(rstn) // R3
      |-> core_rst [*4] ##1 user_mode) else $error("core reset sequence wrong");
   a_pullup_noclamp: assert property ((r_r.state == S_PROG) && !r_r.clamp_en // R4
      |-> (pin_pullup_en == '1) && (pin_oe == '0)) else $error("no pull-up in normal mode");
   a_rt_pins_live: assert property ((r_r.state == S_RTPROG) && !r_r.extest // R5
      |-> (pin_out == user_out) && (pin_oe == user_oe)) else $error("pins not live in RT mode");
   a_rt_no_reload: assert property ((r_r.state == S_RTPROG) && cmd_done // R6
      |=> user_mode && r_r.update_pend && !sram_load [*8]) else $error("RT mode reloaded");
   a_load_length: assert property (sram_load && (r_r.cnt == 16'(CFG_LOAD_CYC - 1)) // R7
      |=> core_rst && !sram_load) else $error("load time wrong");
   a_clamp_drive: assert property (r_r.extest // R9
      |-> (pin_out == r_r.cell_val) && (pin_oe == r_r.cell_oe)) else $error("clamp not driven");
   a_hold_capture: assert property (cmd_preload && !r_r.extest && // R17
      (r_r.clamp_sel[1:0] == CLAMP_HOLD) |=> r_r.cell_oe[0] &&
      (r_r.cell_val[0] == $past(pin_in[0]))) else $error("hold value not captured");
   a_clamp_nopull: assert property (r_r.clamp_en && (r_r.state == S_PROG) // R11
      |-> pin_pullup_en == '0) else $error("pull-up on while clamping");
   a_clamp_release: assert property ((r_r.state == S_PROG) && cmd_done // R14
      |=> !r_r.extest ##[1:300] user_mode) else $error("clamp not released");
   a_combo_refused: assert property ((r_r.state == S_USER) && cmd_start && // R16
      r_r.rt_en && r_r.clamp_en |=> (r_r.state == S_USER) && r_r.err_combo)
      else $error("mixed mode not refused");

   // refusals and corner cases that the scenarios reach once each, or once per clamp pass
   a_clear_loses: assert property ((r_r.state == S_USER) && cmd_start && // R16
      cmd_clrerr && r_r.rt_en && r_r.clamp_en
      |=> r_r.err_combo) else $error("clear beat a refusal");
   a_start_ignored: assert property (cmd_start && !cmd_done && (r_r.state == S_PROG) // R8
      |=> r_r.state == S_PROG) else $error("start taken outside user mode");
   a_mode_locked: assert property (wr_ctrl && (r_r.state != S_USER) // R16
      |=> $stable(r_r.rt_en) && $stable(r_r.clamp_en))
      else $error("mode bits changed outside user mode");
   a_done_ignored: assert property (cmd_done && (r_r.state == S_USER) // R1
      |=> !sram_load) else $error("load without programming");
   a_pend_kept: assert property (r_r.update_pend && user_mode // R6
      |=> r_r.update_pend && !sram_load) else $error("pending update lost or loaded");
   a_extest_refused: assert property (cmd_extest && !r_r.clamp_en && !r_r.extest // R13
      |=> !r_r.extest) else $error("external test entered without clamp");
   a_extest_entry: assert property (cmd_extest && r_r.clamp_en && !cmd_done && // R13
      ((r_r.state == S_USER) || (r_r.state == S_PROG))
      |=> r_r.extest && (pin_oe == r_r.cell_oe)) else $error("external test not entered");
   a_cells_frozen: assert property (r_r.extest && cmd_preload // R12
      |=> $stable(r_r.cell_val) && $stable(r_r.cell_oe))
      else $error("cells changed while driving pins");

   // each pin's cell follows its own code, not only pin 0
   for (genvar g = 0; g < NPIN; g++)
   begin : g_cell_chk
      a_cell_code: assert property (@(posedge clock) disable iff (!rstn) // R10
         cmd_preload && !r_r.extest |=>
         (r_r.cell_oe[g] == ($past(r_r.clamp_sel[2*g +: 2]) != CLAMP_HIZ)) &&
         (r_r.cell_val[g] == (($past(r_r.clamp_sel[2*g +: 2]) == CLAMP_HIGH) ||
         (($past(r_r.clamp_sel[2*g +: 2]) == CLAMP_HOLD) && $past(pin_in[g])))))
         else $error("cell does not follow its clamp code");
   end

   c_normal_prog: cover property ((r_r.state == S_PROG) ##1 sram_load);
   c_rt_prog: cover property ((r_r.state == S_RTPROG) ##1 r_r.update_pend);
   c_clamp_prog: cover property (r_r.extest && (r_r.state == S_PROG) && cmd_done);
   c_combo: cover property ($rose(r_r.err_combo));
   c_hold_capture: cover property (cmd_preload && (r_r.clamp_sel[1:0] == CLAMP_HOLD));
endmodule

/* File: verilog/imc_pkg.sv */
/*
   imc_pkg: constants, register map and types for the programming-mode and
   pin clamp controller. Assumes a 100 MHz system clock and a plain register
   port with one-cycle strobes.
*/
package imc_pkg;
   localparam int          NPIN            = 8;
   localparam int          AW              = 8;
   localparam int          DW              = 32;

   // register byte offsets
   localparam logic [7:0]  ADDR_CTRL       = 8'h00;
   localparam logic [7:0]  ADDR_CMD        = 8'h04;
   localparam logic [7:0]  ADDR_CLAMP      = 8'h08;
   localparam logic [7:0]  ADDR_STAT       = 8'h0C;
   localparam logic [7:0]  ADDR_CELL       = 8'h10;

   // control fields
   localparam int          CTRL_RT_BIT     = 0;
   localparam int          CTRL_CLAMP_BIT  = 1;
   // command fields (write-only, self clearing)
   localparam int          CMD_START_BIT   = 0;
   localparam int          CMD_DONE_BIT    = 1;
   localparam int          CMD_PRELOAD_BIT = 2;
   localparam int          CMD_EXTEST_BIT  = 3;
   localparam int          CMD_CLRERR_BIT  = 4;
   // status fields
   localparam int          ST_STATE_LSB    = 0;
   localparam int          ST_EXTEST_BIT   = 3;
   localparam int          ST_PEND_BIT     = 4;
   localparam int          ST_ERR_BIT      = 5;
   localparam int          ST_LOAD_BIT     = 6;
   localparam int          ST_USER_BIT     = 7;
   // cell register fields
   localparam int          CELL_OE_LSB     = 8;

   // reset values
   localparam logic [1:0]  CTRL_RST        = 2'h0;
   localparam logic [15:0] CLAMP_RST       = 16'h0000;

   // timing
   localparam int          CLK_PERIOD_NS   = 10;
   localparam int          CFG_LOAD_TIME_NS = 1000;
   localparam int          CFG_LOAD_CYC_DEF =
      (CFG_LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          CORE_RST_CYC    = 4;

   typedef enum logic [1:0]
   {
      CLAMP_HIZ  = 2'h0,
      CLAMP_HIGH = 2'h1,
      CLAMP_LOW  = 2'h2,
      CLAMP_HOLD = 2'h3
   } imc_clamp_t;

   typedef enum logic [2:0]
   {
      S_LOAD,
      S_CORE_RST,
      S_USER,
      S_PROG,
      S_RTPROG
   } imc_state_t;

   typedef struct packed
   {
      imc_state_t        state;
      logic [15:0]       cnt;
      logic              rt_en;
      logic              clamp_en;
      logic [15:0]       clamp_sel;
      logic [NPIN-1:0]   cell_val;
      logic [NPIN-1:0]   cell_oe;
      logic              extest;
      logic              update_pend;
      logic              err_combo;
      logic [DW-1:0]     rdata;
   } imc_regs_t;
endpackage

/* File: tb/imc_host_model.sv */
/*
   imc_host_model: programming host on the plain register port.
   assumes a free-running clock and a slave that never stalls.
*/
`timescale 1ns/1ps
module imc_host_model
(
   // clock
   input  wire logic                   clock,
   // register port
   output      logic [imc_pkg::AW-1:0] reg_addr,
   output      logic [imc_pkg::DW-1:0] reg_wdata,
   output      logic                   reg_wr,
   output      logic                   reg_rd,
   input  wire logic [imc_pkg::DW-1:0] reg_rdata
);
   import imc_pkg::*;

   initial
   begin
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // idle bus shows the inverse, so a stale value can never pass for a match
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(negedge clock);
      d = reg_rdata;
   endtask
endmodule

/* File: tb/isp_mode_and_pin_clamp_control_tb.sv */
/*
   isp_mode_and_pin_clamp_control_tb: self-checking bench for imc_ctrl.
   assumes imc_pkg and imc_ctrl compiled first; load time shortened to 5.
*/
`timescale 1ns/1ps
module isp_mode_and_pin_clamp_control_tb;
   import imc_pkg::*;
   localparam int LOAD = 5;
   logic            clock;
   logic            rstn;
   logic [AW-1:0]   reg_addr;
   logic [DW-1:0]   reg_wdata;
   logic            reg_wr;
   logic            reg_rd;
   logic [DW-1:0]   reg_rdata;
   logic [NPIN-1:0] pin_in, pin_out, pin_oe, pin_pullup_en;
   logic [NPIN-1:0] user_out, user_oe, user_in;
   logic            sram_load, core_rst, user_mode;
   logic [DW-1:0]   rv;
   logic [15:0]     sel, e;
   logic [7:0]      smp;
   int              n_fail, cmp_count;

   imc_ctrl #(.CFG_LOAD_CYC(LOAD)) i_dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
      .user_out(user_out), .user_oe(user_oe), .user_in(user_in), .sram_load(sram_load),
      .core_rst(core_rst), .user_mode(user_mode));
   imc_host_model i_host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   function automatic logic [DW-1:0] st(input int s, input logic pend, input logic err);
      return 32'(s) | (32'(pend) << ST_PEND_BIT) | (32'(err) << ST_ERR_BIT) |
         (32'(s == 0) << ST_LOAD_BIT) | (32'(s == 2) << ST_USER_BIT);
   endfunction

   // returns {oe, out} per pin for the clamp codes and the sampled levels
   function automatic logic [15:0] clamp_exp(input logic [15:0] s, input logic [7:0] p);
      logic [15:0] r;
      r = '0;
      for (int i = 0; i < NPIN; i++)
      begin
         r[8+i] = (s[2*i+:2] != CLAMP_HIZ);
         r[i] = (s[2*i+:2] == CLAMP_HIGH) || (s[2*i+:2] == CLAMP_HOLD && p[i]);
      end
      return r;
   endfunction

   task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
      i_host.rd(a, rv);
      chk(rv, exp);
   endtask

   task automatic drive_user;
      @(posedge clock);
      user_out <= NPIN'($urandom);
      user_oe <= NPIN'($urandom);
      pin_in <= NPIN'($urandom);
      @(negedge clock);
   endtask

   // call at a falling edge with the load already under way
   task automatic load_seq(input int exp_n);
      int n;
      int k;
      n = 0;
      k = 0;
      while (sram_load === 1'b1 && n < 50)
      begin
         chk(32'(pin_oe), 32'h0000_0000);
         n++;
         @(negedge clock);
      end
      while (core_rst === 1'b1 && k < 20)
      begin
         k++;
         @(negedge clock);
      end
      if (exp_n > 0)
         chk(32'(n), 32'(exp_n));
      chk(32'(k), 32'(CORE_RST_CYC));
      chk(32'(user_mode), 32'h0000_0001);
   endtask

   task automatic power_up;
      @(posedge clock);
      rstn <= 1'b0;
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      @(negedge clock);
      chk(32'(sram_load), 32'h0000_0001);
      load_seq(0);
   endtask

   initial
   begin
      n_fail = 0;
      cmp_count = 0;
      rstn = 1'b0;
      pin_in = '0;
      user_out = '0;
      user_oe = '0;
      void'($urandom(76));
      power_up();
      rchk(ADDR_CTRL, 32'(CTRL_RST));
      rchk(ADDR_CLAMP, 32'(CLAMP_RST));
      rchk(8'h20, 32'h0000_0000);
      rchk(ADDR_STAT, st(2, 0, 0));
      @(negedge clock);
      chk(reg_rdata, 32'h0000_0000);
      i_host.wr(ADDR_CMD, 32'h0000_0002);
      @(negedge clock);
      chk(32'(sram_load), 32'h0000_0000);
      $display("test reset done");
      // background programming, started only in user mode
      i_host.wr(ADDR_CTRL, 32'h0000_0001);
      i_host.wr(ADDR_CMD, 32'h0000_0001);
      repeat (8)
      begin
         drive_user();
         chk(32'({pin_oe, pin_out, user_in}), 32'({user_oe, user_out, pin_in}));
         chk(32'(user_mode), 32'h0000_0001);
      end
      rchk(ADDR_STAT, st(4, 0, 0));
      i_host.wr(ADDR_CMD, 32'h0000_0002);
      @(negedge clock);
      chk(32'(sram_load), 32'h0000_0000);
      rchk(ADDR_STAT, st(2, 1, 0));
      power_up();
      rchk(ADDR_STAT, st(2, 0, 0));
      $display("test background done");
      // clamp together with background programming is refused
      i_host.wr(ADDR_CTRL, 32'h0000_0003);
      i_host.wr(ADDR_CMD, 32'h0000_0011);
      rchk(ADDR_STAT, st(2, 0, 1));
      i_host.wr(ADDR_CMD, 32'h0000_0010);
      rchk(ADDR_STAT, st(2, 0, 0));
      i_host.wr(ADDR_CTRL, 32'h0000_0000);
      // normal programming without clamp
      i_host.wr(ADDR_CMD, 32'h0000_0001);
      i_host.wr(ADDR_CMD, 32'h0000_0009);
      i_host.wr(ADDR_CTRL, 32'h0000_0003);
      drive_user();
      chk(32'({pin_oe, pin_pullup_en}), 32'h0000_00ff);
      chk(32'(user_mode), 32'h0000_0000);
      i_host.wr(ADDR_CMD, 32'h0000_0002);
      @(negedge clock);
      load_seq(LOAD);
      rchk(ADDR_CTRL, 32'h0000_0000);
      $display("test normal done");
      // clamped programming: every code in pass 0, random codes after
      for (int p = 0; p < 3; p++)
      begin
         sel = (p == 0) ? 16'he4e7 : 16'($urandom);
         smp = 8'($urandom);
         i_host.wr(ADDR_CTRL, 32'h0000_0002);
         i_host.wr(ADDR_CLAMP, 32'(sel));
         @(posedge clock);
         pin_in <= smp;
         i_host.wr(ADDR_CMD, 32'h0000_0004);
         i_host.wr(ADDR_CMD, 32'h0000_0008);
         i_host.wr(ADDR_CMD, 32'h0000_0001);
         pin_in <= ~smp;
         i_host.wr(ADDR_CMD, 32'h0000_0004);
         repeat (3) @(negedge clock);
         e = clamp_exp(sel, smp);
         chk(32'(pin_oe), 32'(e[15:8]));
         chk(32'(pin_out & e[15:8]), 32'(e[7:0] & e[15:8]));
         chk(32'(pin_pullup_en), 32'h0000_0000);
         rchk(ADDR_CELL, 32'(e));
         i_host.wr(ADDR_CMD, 32'h0000_0002);
         @(negedge clock);
         load_seq(LOAD);
         drive_user();
         chk(32'({pin_oe, pin_out}), 32'({user_oe, user_out}));
      end
      $display("test clamp done");
      conclude();
   end

   initial
   begin
      #200000;
      n_fail++;
      conclude();
   end
endmodule
